/* File: common/gpio_alarm_pkg.sv */
package gpio_alarm_pkg;

   // --------
   // Sizes
   // --------
   localparam int MAX_PINS = 9;
   localparam int NUM_SLOTS = 32;
   localparam int SLOT_W = 5;
   localparam int PAT_BYTES = 4;

   // --------
   // Timing: one alarm second counted at the system clock rate
   // --------
   localparam longint CLK_FREQ_HZ = 100_000_000;
   localparam longint TICK_PERIOD_S = 1;
   localparam logic [31:0] SEC_CYCLES = 32'(TICK_PERIOD_S * CLK_FREQ_HZ);

   // --------
   // Register byte offsets
   // --------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PRESCALE = 8'h04;
   localparam logic [7:0] OFF_PIN_FUNC = 8'h08;
   localparam logic [7:0] OFF_PIN_OUT = 8'h0c;
   localparam logic [7:0] OFF_PIN_LEVEL = 8'h10;
   localparam logic [7:0] OFF_SLOT_SEL = 8'h14;
   localparam logic [7:0] OFF_SLOT_CFG = 8'h18;
   localparam logic [7:0] OFF_SLOT_COND = 8'h1c;
   localparam logic [7:0] OFF_SLOT_TIME = 8'h20;
   localparam logic [7:0] OFF_SLOT_PAT = 8'h24;
   localparam logic [7:0] OFF_STATUS = 8'h28;
   localparam logic [7:0] OFF_MASK = 8'h2c;
   localparam logic [7:0] OFF_LAST = 8'h30;

   // --------
   // Field positions
   // --------
   localparam int CTRL_EN_BIT = 0;
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_TYPE_BIT = 1;
   localparam int CFG_TRAP_BIT = 2;
   localparam int CFG_MAIL_BIT = 3;
   localparam int CFG_REM_BIT = 4;
   localparam int CFG_PORT_BIT = 5;
   localparam int CFG_LEN_LSB = 6;
   localparam int COND_HIGH_LSB = 0;
   localparam int COND_CARE_LSB = 16;
   localparam int TIME_REC_LSB = 0;
   localparam int TIME_REM_LSB = 16;
   localparam int LAST_REM_BIT = 8;
   localparam int LAST_TRAP_BIT = 9;
   localparam int LAST_MAIL_BIT = 10;

   // --------
   // Reset values
   // --------
   localparam logic CTRL_RST = 1'b0;
   localparam logic [31:0] MASK_RST = 32'h0000_0000;

   // Serial-function direction: pins 3, 4, 5 and 7 are outputs.
   localparam logic [MAX_PINS-1:0] SER_OUT_MASK = 9'h0b8;

   typedef enum logic [1:0]
   {
      FUNC_SERIAL = 2'b00,
      FUNC_IN = 2'b01,
      FUNC_OUT = 2'b10
   } pin_func_e;

endpackage

/* File: core/pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// A level taken from a pad is accepted once stages two and three agree.
module pin_sync
#(
   parameter int WIDTH = 9
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Raw and filtered levels
   input wire logic [WIDTH-1:0] raw,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] s1_r;
   logic [WIDTH-1:0] s2_r;
   logic [WIDTH-1:0] s3_r;

   // Three stages; only the second stage reads the first.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end
      else
      begin
         s1_r <= raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Per bit, a change is taken only when the late stages agree.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         level <= '0;
      else
         level <= (level & (s2_r ^ s3_r)) | (s2_r & s3_r);
   end

endmodule // pin_sync

`default_nettype wire

/* File: core/sec_tick.sv */
`timescale 1ns/1ps
`default_nettype none

// One-cycle tick every (period + 1) clocks; a new period takes effect at once.
module sec_tick
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Period in cycles minus one, and tick
   input wire logic [31:0] period,
   output logic tick
);

   logic [31:0] cnt_r;

   // Counter wraps when it reaches the period, so a shorter value never hangs it.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
         tick <= 1'b0;
      end
      else if (cnt_r >= period)
      begin
         cnt_r <= '0;
         tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 32'h0000_0001;
         tick <= 1'b0;
      end
   end

endmodule // sec_tick

`default_nettype wire

/* File: core/gpio_alarm_monitor.sv */
// Functional notes
// - Each pin picks serial, input or output.
// - Reset leaves every pin in serial function.
// - Serial function uses fixed pin direction map.
// - Pin count is five or nine.
// - Output pins drive the software-written level.
// - Thirty-two slots, each with own enable.
// - Global enable gates every alarm and reminder.
// - Slot type selects pin or pattern trigger.
// - Per-pin high, low or ignore condition.
// - Recurrence interval suppresses repeated alarms.
// - Reminders repeat while pin match persists.
// - Pattern slot matches received serial bytes.
// - Alarm carries trap and mail request flags.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module gpio_alarm_monitor
#(
   parameter int NPINS = 9,
   parameter logic [31:0] SEC_CYCLES = gpio_alarm_pkg::SEC_CYCLES
)
(
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [NPINS-1:0] pin_i,
   output logic [NPINS-1:0] pin_o,
   output logic [NPINS-1:0] pin_oe_n,
   // Serial port side
   input wire logic [NPINS-1:0] ser_drive,
   output logic [NPINS-1:0] ser_sense,
   input wire logic rx_valid,
   input wire logic rx_port,
   input wire logic [7:0] rx_data,
   // Alarm events
   output logic irq,
   output logic alarm_pulse,
   output logic remind_pulse,
   output logic alarm_trap,
   output logic alarm_mail,
   output logic [4:0] alarm_slot
);

   localparam int NS = gpio_alarm_pkg::NUM_SLOTS;

   // --------
   // Parameter check
   // --------
   if (NPINS != 5 && NPINS != 9)
   begin : g_bad_npins
      $error("NPINS must be 5 or 9");
   end

   // --------
   // Declarations
   // --------
   logic ctrl_en_r;
   logic [31:0] prescale_r;
   logic [2*NPINS-1:0] func_r;
   logic [NPINS-1:0] pout_r;
   logic [4:0] sel_r;
   logic [7:0] cfg_r [NS];
   logic [NPINS-1:0] high_r [NS];
   logic [NPINS-1:0] care_r [NS];
   logic [31:0] time_r [NS];
   logic [31:0] pat_r [NS];
   logic [31:0] status_r;
   logic [31:0] mask_r;
   logic [10:0] last_r;
   logic [31:0] hist_r [2];
   logic [NPINS-1:0] pin_lvl;
   logic tick;
   logic [NS-1:0] raise_v;
   logic [NS-1:0] remind_v;
   logic [NS-1:0] fire_v;
   logic acc_done;
   logic [31:0] rd_data;
   logic rd_ok;
   logic [31:0] win0;
   logic [31:0] win1;

   // --------
   // Helpers
   // --------
   // Byte 0 of the pattern is the most recently received byte.
   function automatic logic pat_hit(input logic [31:0] win, input logic [31:0] pat,
                                    input logic [1:0] len);
      logic hit;
      hit = 1'b1;
      for (int i = 0; i < gpio_alarm_pkg::PAT_BYTES; i++)
      begin
         if (i <= int'(len) && win[8*i +: 8] != pat[8*i +: 8])
            hit = 1'b0;
      end
      return hit;
   endfunction

   function automatic logic [4:0] first_set(input logic [NS-1:0] v);
      logic [4:0] idx;
      idx = '0;
      for (int i = NS - 1; i >= 0; i--)
      begin
         if (v[i])
            idx = 5'(i);
      end
      return idx;
   endfunction

   // --------
   // Submodules
   // --------
   pin_sync #(.WIDTH(NPINS)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .raw(pin_i),
      .level(pin_lvl)
   );

   sec_tick u_tick
   (
      .pclk(pclk),
      .presetn(presetn),
      .period(prescale_r),
      .tick(tick)
   );

   // --------
   // APB slave
   // --------
   // Every access takes one wait state, so read data comes from a flop.
   assign acc_done = psel && penable && pready;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else if (psel && penable && !pready)
      begin
         pready <= 1'b1;
         prdata <= pwrite ? 32'h0000_0000 : rd_data;
         pslverr <= !rd_ok;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Read decode; slot registers show the slot chosen by the select register.
   always_comb
   begin
      rd_data = '0;
      rd_ok = 1'b1;
      case (paddr)
         gpio_alarm_pkg::OFF_CTRL: rd_data[gpio_alarm_pkg::CTRL_EN_BIT] = ctrl_en_r;
         gpio_alarm_pkg::OFF_PRESCALE: rd_data = prescale_r;
         gpio_alarm_pkg::OFF_PIN_FUNC: rd_data[2*NPINS-1:0] = func_r;
         gpio_alarm_pkg::OFF_PIN_OUT: rd_data[NPINS-1:0] = pout_r;
         gpio_alarm_pkg::OFF_PIN_LEVEL: rd_data[NPINS-1:0] = pin_lvl;
         gpio_alarm_pkg::OFF_SLOT_SEL: rd_data[4:0] = sel_r;
         gpio_alarm_pkg::OFF_SLOT_CFG: rd_data[7:0] = cfg_r[sel_r];
         gpio_alarm_pkg::OFF_SLOT_COND:
         begin
            rd_data[gpio_alarm_pkg::COND_HIGH_LSB +: NPINS] = high_r[sel_r];
            rd_data[gpio_alarm_pkg::COND_CARE_LSB +: NPINS] = care_r[sel_r];
         end
         gpio_alarm_pkg::OFF_SLOT_TIME: rd_data = time_r[sel_r];
         gpio_alarm_pkg::OFF_SLOT_PAT: rd_data = pat_r[sel_r];
         gpio_alarm_pkg::OFF_STATUS: rd_data = status_r;
         gpio_alarm_pkg::OFF_MASK: rd_data = mask_r;
         gpio_alarm_pkg::OFF_LAST: rd_data[10:0] = last_r;
         default: rd_ok = 1'b0;
      endcase
   end

   // Global control, prescaler, pin setup and mask.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_en_r <= gpio_alarm_pkg::CTRL_RST;
         prescale_r <= SEC_CYCLES - 32'h0000_0001;
         func_r <= '0;
         pout_r <= '0;
         sel_r <= '0;
         mask_r <= gpio_alarm_pkg::MASK_RST;
      end
      else if (acc_done && pwrite)
      begin
         case (paddr)
            gpio_alarm_pkg::OFF_CTRL: ctrl_en_r <= pwdata[gpio_alarm_pkg::CTRL_EN_BIT];
            gpio_alarm_pkg::OFF_PRESCALE: prescale_r <= pwdata;
            gpio_alarm_pkg::OFF_PIN_FUNC: func_r <= pwdata[2*NPINS-1:0];
            gpio_alarm_pkg::OFF_PIN_OUT: pout_r <= pwdata[NPINS-1:0];
            gpio_alarm_pkg::OFF_SLOT_SEL: sel_r <= pwdata[4:0];
            gpio_alarm_pkg::OFF_MASK: mask_r <= pwdata;
            default: ;
         endcase
      end
   end

   // Slot configuration storage; reset clears every field, not only the enable.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int s = 0; s < NS; s++)
         begin
            cfg_r[s] <= '0;
            high_r[s] <= '0;
            care_r[s] <= '0;
            time_r[s] <= '0;
            pat_r[s] <= '0;
         end
      end
      else if (acc_done && pwrite)
      begin
         case (paddr)
            gpio_alarm_pkg::OFF_SLOT_CFG: cfg_r[sel_r] <= pwdata[7:0];
            gpio_alarm_pkg::OFF_SLOT_COND:
            begin
               high_r[sel_r] <= pwdata[gpio_alarm_pkg::COND_HIGH_LSB +: NPINS];
               care_r[sel_r] <= pwdata[gpio_alarm_pkg::COND_CARE_LSB +: NPINS];
            end
            gpio_alarm_pkg::OFF_SLOT_TIME: time_r[sel_r] <= pwdata;
            gpio_alarm_pkg::OFF_SLOT_PAT: pat_r[sel_r] <= pwdata;
            default: ;
         endcase
      end
   end

   // --------
   // Pin functions
   // --------
   // Serial-function direction is fixed per pin; code 2'b11 acts as serial.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_o <= '0;
         pin_oe_n <= '1;
         ser_sense <= '0;
      end
      else
      begin
         for (int p = 0; p < NPINS; p++)
         begin
            if (func_r[2*p +: 2] == gpio_alarm_pkg::FUNC_OUT)
            begin
               pin_o[p] <= pout_r[p];
               pin_oe_n[p] <= 1'b0;
               ser_sense[p] <= 1'b0;
            end
            else if (func_r[2*p +: 2] == gpio_alarm_pkg::FUNC_IN)
            begin
               pin_o[p] <= 1'b0;
               pin_oe_n[p] <= 1'b1;
               ser_sense[p] <= 1'b0;
            end
            else if (gpio_alarm_pkg::SER_OUT_MASK[p])
            begin
               pin_o[p] <= ser_drive[p];
               pin_oe_n[p] <= 1'b0;
               ser_sense[p] <= 1'b0;
            end
            else
            begin
               pin_o[p] <= 1'b0;
               pin_oe_n[p] <= 1'b1;
               ser_sense[p] <= pin_lvl[p];
            end
         end
      end
   end

   // --------
   // Received byte history, one per serial port
   // --------
   assign win0 = {hist_r[0][23:0], rx_data};
   assign win1 = {hist_r[1][23:0], rx_data};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         hist_r[0] <= '0;
         hist_r[1] <= '0;
      end
      else if (rx_valid)
         hist_r[rx_port] <= rx_port ? win1 : win0;
   end

   // --------
   // Alarm slots
   // --------
   for (genvar s = 0; s < NS; s++)
   begin : g_slot
      logic active;
      logic match;
      logic match_prev_r;
      logic trig;
      logic [15:0] hold_r;
      logic [15:0] rem_cnt_r;
      logic [15:0] rec_sec;
      logic [15:0] rem_sec;

      assign rec_sec = time_r[s][gpio_alarm_pkg::TIME_REC_LSB +: 16];
      assign rem_sec = time_r[s][gpio_alarm_pkg::TIME_REM_LSB +: 16];
      assign active = ctrl_en_r && cfg_r[s][gpio_alarm_pkg::CFG_EN_BIT];
      assign match = !cfg_r[s][gpio_alarm_pkg::CFG_TYPE_BIT]
                     && &((pin_lvl ~^ high_r[s]) | ~care_r[s]);

      // Pin slots fire on the match edge, pattern slots on a full byte match.
      always_comb
      begin
         if (cfg_r[s][gpio_alarm_pkg::CFG_TYPE_BIT])
            trig = rx_valid && (rx_port == cfg_r[s][gpio_alarm_pkg::CFG_PORT_BIT])
                   && pat_hit(rx_port ? win1 : win0, pat_r[s],
                              cfg_r[s][gpio_alarm_pkg::CFG_LEN_LSB +: 2]);
         else
            trig = match && !match_prev_r;
      end

      assign raise_v[s] = active && trig && hold_r == 16'h0000;
      assign remind_v[s] = active && cfg_r[s][gpio_alarm_pkg::CFG_REM_BIT] && match
                           && tick && rem_sec != 16'h0000
                           && rem_cnt_r == rem_sec - 16'h0001;

      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            match_prev_r <= 1'b0;
         else
            match_prev_r <= match;
      end

      // Hold-off counts down whole seconds; a tick may shorten the first one.
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            hold_r <= '0;
         else if (!active)
            hold_r <= '0;
         else if (raise_v[s])
            hold_r <= rec_sec;
         else if (tick && hold_r != 16'h0000)
            hold_r <= hold_r - 16'h0001;
      end

      // The reminder period restarts whenever the pins leave the state.
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            rem_cnt_r <= '0;
         else if (!active || !match || !cfg_r[s][gpio_alarm_pkg::CFG_REM_BIT])
            rem_cnt_r <= '0;
         else if (remind_v[s])
            rem_cnt_r <= '0;
         else if (tick)
            rem_cnt_r <= rem_cnt_r + 16'h0001;
      end
   end

   assign fire_v = raise_v | remind_v;

   // --------
   // Event outputs, status and interrupt
   // --------
   // The lowest firing slot is reported when several fire together.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         alarm_pulse <= 1'b0;
         remind_pulse <= 1'b0;
         alarm_trap <= 1'b0;
         alarm_mail <= 1'b0;
         alarm_slot <= '0;
         last_r <= '0;
      end
      else
      begin
         alarm_pulse <= |raise_v;
         remind_pulse <= |remind_v;
         alarm_trap <= |fire_v && cfg_r[first_set(fire_v)][gpio_alarm_pkg::CFG_TRAP_BIT];
         alarm_mail <= |fire_v && cfg_r[first_set(fire_v)][gpio_alarm_pkg::CFG_MAIL_BIT];
         alarm_slot <= first_set(fire_v);
         if (|fire_v)
         begin
            last_r[4:0] <= first_set(fire_v);
            last_r[gpio_alarm_pkg::LAST_REM_BIT] <= !raise_v[first_set(fire_v)];
            last_r[gpio_alarm_pkg::LAST_TRAP_BIT] <=
               cfg_r[first_set(fire_v)][gpio_alarm_pkg::CFG_TRAP_BIT];
            last_r[gpio_alarm_pkg::LAST_MAIL_BIT] <=
               cfg_r[first_set(fire_v)][gpio_alarm_pkg::CFG_MAIL_BIT];
         end
      end
   end

   // A read clears only the bits it returned, so a new event is never lost.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         status_r <= '0;
      else if (acc_done && !pwrite && paddr == gpio_alarm_pkg::OFF_STATUS)
         status_r <= (status_r & ~prdata) | fire_v;
      else
         status_r <= status_r | fire_v;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq <= 1'b0;
      else
         irq <= |(status_r & mask_r);
   end

endmodule // gpio_alarm_monitor

`default_nettype wire

/* File: testbench/gpio_alarm_monitor_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module gpio_alarm_monitor_assertions
#(
   parameter int NPINS = 9
)
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins and events
   input wire logic [NPINS-1:0] pin_o,
   input wire logic [NPINS-1:0] pin_oe_n,
   input wire logic [NPINS-1:0] ser_sense,
   input wire logic alarm_pulse,
   input wire logic remind_pulse,
   input wire logic alarm_trap,
   input wire logic alarm_mail
);
   logic wr, en_r, calm;
   logic [2*NPINS-1:0] func_r, func_d;
   logic [NPINS-1:0] out_r, out_d, om, im, sm;

   function automatic logic [NPINS-1:0] pick(input logic [2*NPINS-1:0] f, input logic [1:0] c);
      for (int p = 0; p < NPINS; p++) pick[p] = (f[2*p +: 2] == c);
   endfunction

   // Shadow copies of the steering registers; pins lag them by one cycle.
   assign wr = psel && penable && pready && pwrite;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_r <= 1'b0;
         func_r <= '0;
         out_r <= '0;
         func_d <= '0;
         out_d <= '0;
      end
      else
      begin
         func_d <= func_r;
         out_d <= out_r;
         if (wr && paddr == gpio_alarm_pkg::OFF_CTRL) en_r <= pwdata[0];
         if (wr && paddr == gpio_alarm_pkg::OFF_PIN_FUNC) func_r <= pwdata[2*NPINS-1:0];
         if (wr && paddr == gpio_alarm_pkg::OFF_PIN_OUT) out_r <= pwdata[NPINS-1:0];
      end
   end

   // Pin masks per function; checks wait until the shadow has settled.
   assign calm = (func_r == func_d) && (out_r == out_d);
   assign om = pick(func_d, 2'b10);
   assign im = pick(func_d, 2'b01);
   assign sm = (pick(func_d, 2'b00) | pick(func_d, 2'b11)) & ~gpio_alarm_pkg::SER_OUT_MASK[NPINS-1:0];

   // --------
   // Properties
   // --------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_answer; !pready ##1 pready; endsequence
   property p_wait; s_setup |=> s_answer; endproperty
   property p_once; pready |=> !pready; endproperty
   property p_err; pslverr |-> pready; endproperty
   property p_out; calm |-> (pin_oe_n & om) == '0 && ((pin_o ^ out_d) & om) == '0; endproperty
   property p_in; calm |-> (pin_oe_n & im) == im; endproperty
   property p_ser; calm |-> (pin_oe_n & sm) == sm; endproperty
   property p_sense; calm |-> (ser_sense & (om | im)) == '0; endproperty
   property p_gate; !en_r && !$past(en_r) |-> !alarm_pulse && !remind_pulse; endproperty
   property p_flags; alarm_trap || alarm_mail |-> alarm_pulse || remind_pulse; endproperty
   a_wait: assert property (p_wait) else $error("late pready");
   a_once: assert property (p_once) else $error("pready held too long");
   a_err: assert property (p_err) else $error("pslverr without pready");
   a_out: assert property (p_out) else $error("output pin not driven");
   a_in: assert property (p_in) else $error("input pin driven");
   a_ser: assert property (p_ser) else $error("serial input pin driven");
   a_sense: assert property (p_sense) else $error("sense on user pin");
   a_gate: assert property (p_gate) else $error("event while disabled");
   a_flags: assert property (p_flags) else $error("flag without event");
endmodule // gpio_alarm_monitor_assertions

bind gpio_alarm_monitor gpio_alarm_monitor_assertions #(.NPINS(NPINS)) i_chk (.pclk(pclk),
   .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
   .ser_sense(ser_sense), .alarm_pulse(alarm_pulse), .remind_pulse(remind_pulse),
   .alarm_trap(alarm_trap), .alarm_mail(alarm_mail));

`default_nettype wire

/* File: testbench/serial_equipment.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_equipment
#(
   parameter int NPINS = 9
)
(
   // Device drive
   input wire logic [NPINS-1:0] pin_o,
   input wire logic [NPINS-1:0] pin_oe_n,
   // Level the equipment puts on pins it owns
   input wire logic [NPINS-1:0] drive_level,
   // Wire level seen by the device
   output logic [NPINS-1:0] pin_i
);
   // The equipment samples pins the device drives and drives all others.
   assign pin_i = (~pin_oe_n & pin_o) | (pin_oe_n & drive_level);
endmodule // serial_equipment

`default_nettype wire

/* File: testbench/gpio_alarm_monitor_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module gpio_alarm_monitor_tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_s;
   logic pclk, presetn, psel, penable, pwrite, rx_valid, rx_port, pready, pslverr, e;
   logic irq, alarm_pulse, remind_pulse, alarm_trap, alarm_mail, a_seen, r_seen, tr, ml;
   logic [7:0] paddr, rx_data;
   logic [31:0] pwdata, prdata, q;
   logic [4:0] alarm_slot, slot;
   logic [8:0] pin_i, pin_o, pin_oe_n, ser_drive, ser_sense, level;
   int n_errors, checked;
   row_s rows [6] = '{
      '{gpio_alarm_pkg::OFF_PRESCALE, 32'h0000_0009, 32'h0000_0009, 1'b0},
      '{gpio_alarm_pkg::OFF_SLOT_SEL, 32'h0000_001f, 32'h0000_001f, 1'b0},
      '{gpio_alarm_pkg::OFF_MASK, 32'hffff_ffff, 32'hffff_ffff, 1'b0},
      '{gpio_alarm_pkg::OFF_CTRL, 32'h0000_0001, 32'h0000_0001, 1'b0},
      '{gpio_alarm_pkg::OFF_STATUS, 32'hffff_ffff, 32'h0000_0000, 1'b0},
      '{8'h34, 32'h0000_0005, 32'h0000_0000, 1'b1}};

   gpio_alarm_monitor #(.NPINS(9), .SEC_CYCLES(32'd10)) i_dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i), .pin_o(pin_o),
      .pin_oe_n(pin_oe_n), .ser_drive(ser_drive), .ser_sense(ser_sense), .rx_valid(rx_valid),
      .rx_port(rx_port), .rx_data(rx_data), .irq(irq), .alarm_pulse(alarm_pulse),
      .remind_pulse(remind_pulse), .alarm_trap(alarm_trap), .alarm_mail(alarm_mail),
      .alarm_slot(alarm_slot));
   serial_equipment #(.NPINS(9)) i_equip (.pin_o(pin_o), .pin_oe_n(pin_oe_n),
      .drive_level(level), .pin_i(pin_i));

   // --------
   // Tasks
   // --------
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected word at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_word(32'(got), 32'(exp));
   endtask

   // The request is held until pready is seen high at a rising edge, or for at most 20 edges.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk_word(q, x);
   endtask

   // Records any alarm or reminder over n cycles, with the alarm's flags.
   task automatic watch(input int n);
      a_seen = 1'b0;
      r_seen = 1'b0;
      repeat (n)
      begin
         @(posedge pclk);
         if (alarm_pulse === 1'b1) {a_seen, tr, ml, slot} = {1'b1, alarm_trap, alarm_mail, alarm_slot};
         if (remind_pulse === 1'b1) r_seen = 1'b1;
      end
   endtask

   task automatic send(input logic p, input logic [7:0] b);
      @(posedge pclk);
      {rx_valid, rx_port, rx_data} <= {1'b1, p, b};
      @(posedge pclk);
      rx_valid <= 1'b0;
   endtask

   // A short pin bounce; its rising match lands in the hold-off if one runs.
   task automatic bounce();
      level <= 9'h006;
      repeat (5) @(posedge pclk);
      level <= 9'h002;
   endtask

   task automatic wrap_up();
      $display("errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // --------
   // Stimulus
   // --------
   // Free-running system clock.
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Cuts a hang short; the whole run needs well under this span.
   initial
   begin
      #100us;
      n_errors++;
      wrap_up();
   end

   // Main sequence: register table, then reset and the alarm cases.
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, rx_valid, rx_port, rx_data} = '0;
      {ser_drive, level, n_errors, checked, presetn} = '0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i])
      begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].q);
         chk_bit(e, rows[i].e);
      end
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      chk_word(32'(pin_oe_n), 32'h0000_01ff);
      presetn <= 1'b1;
      rd(gpio_alarm_pkg::OFF_CTRL, 32'h0);
      rd(gpio_alarm_pkg::OFF_PRESCALE, 32'h0000_0009);
      rd(gpio_alarm_pkg::OFF_PIN_FUNC, 32'h0);
      wr(gpio_alarm_pkg::OFF_MASK, 32'hffff_ffff);
      wr(gpio_alarm_pkg::OFF_CTRL, 32'h1);
      level <= 9'h006;
      wr(gpio_alarm_pkg::OFF_PIN_FUNC, 32'h0000_0006);
      wr(gpio_alarm_pkg::OFF_PIN_OUT, 32'h0000_0001);
      repeat (6) @(posedge pclk);
      chk_word(32'(pin_oe_n & 9'h003), 32'h0000_0002);
      chk_word(32'(ser_sense), 32'h0000_0004);
      rd(gpio_alarm_pkg::OFF_PIN_LEVEL, 32'h0000_0007);
      wr(gpio_alarm_pkg::OFF_SLOT_SEL, 32'h0);
      wr(gpio_alarm_pkg::OFF_SLOT_COND, 32'h0006_0002);
      wr(gpio_alarm_pkg::OFF_SLOT_TIME, 32'h0000_0003);
      wr(gpio_alarm_pkg::OFF_SLOT_CFG, 32'h0000_0005);
      level <= 9'h002;
      watch(10);
      chk_bit(a_seen, 1'b1);
      chk_word(32'({tr, ml, slot}), 32'h0000_0040);
      bounce();
      watch(6);
      chk_bit(a_seen, 1'b0);
      chk_bit(irq, 1'b1);
      rd(gpio_alarm_pkg::OFF_STATUS, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      chk_bit(irq, 1'b0);
      repeat (30) @(posedge pclk);
      bounce();
      watch(10);
      chk_bit(a_seen, 1'b1);
      wr(gpio_alarm_pkg::OFF_SLOT_TIME, 32'h0002_0003);
      wr(gpio_alarm_pkg::OFF_SLOT_CFG, 32'h0000_0015);
      watch(40);
      chk_bit(r_seen, 1'b1);
      wr(gpio_alarm_pkg::OFF_CTRL, 32'h0);
      bounce();
      watch(40);
      chk_bit(a_seen | r_seen, 1'b0);
      wr(gpio_alarm_pkg::OFF_CTRL, 32'h1);
      wr(gpio_alarm_pkg::OFF_SLOT_CFG, 32'h0);
      wr(gpio_alarm_pkg::OFF_SLOT_SEL, 32'h1);
      wr(gpio_alarm_pkg::OFF_SLOT_PAT, 32'h0000_0d0a);
      wr(gpio_alarm_pkg::OFF_SLOT_CFG, 32'h0000_006b);
      send(1'b0, 8'h0d);
      send(1'b0, 8'h0a);
      watch(3);
      chk_bit(a_seen, 1'b0);
      send(1'b1, 8'h0d);
      send(1'b1, 8'h0a);
      watch(3);
      chk_bit(a_seen, 1'b1);
      chk_word(32'({tr, ml, slot}), 32'h0000_0021);
      wrap_up();
   end
endmodule // gpio_alarm_monitor_tb

`default_nettype wire
